// ==== dtc_pkg.sv ====
package dtc_pkg;

	localparam int          NUM_CTR        = 2;
	localparam int          CTR_W          = 16;
	localparam int          PRESCALE_DIV   = 4;
	localparam int          PRESCALE_W     = 2;
	localparam logic [1:0]  PRESCALE_LAST  = 2'(PRESCALE_DIV - 1);

	// Register indices; byte address is four times the index
	localparam logic [5:0]  IDX_IRQ_CTRL   = 6'h0B;
	localparam logic [5:0]  IDX_C0_HIGH    = 6'h0C;
	localparam logic [5:0]  IDX_C0_LOW     = 6'h0D;
	localparam logic [5:0]  IDX_C0_CTRL    = 6'h0E;
	localparam logic [5:0]  IDX_C1_HIGH    = 6'h0F;
	localparam logic [5:0]  IDX_C1_LOW     = 6'h10;
	localparam logic [5:0]  IDX_C1_CTRL    = 6'h11;
	localparam logic [5:0]  IDX_CTR_STRIDE = 6'h03;

	// Control register fields
	localparam int          CTRL_EDGE_BIT  = 3;
	localparam int          CTRL_EN_BIT    = 4;
	localparam int          CTRL_MODE_LSB  = 6;
	localparam logic [7:0]  CTRL_RESET     = 8'h08;

	// Interrupt control register fields
	localparam int          IRQ_EN_LSB     = 2;
	localparam int          IRQ_FLAG_LSB   = 5;

	localparam logic [1:0]  MODE_UNUSED    = 2'h0;
	localparam logic [1:0]  MODE_EVENT     = 2'h1;
	localparam logic [1:0]  MODE_TIMER     = 2'h2;
	localparam logic [1:0]  MODE_PULSE     = 2'h3;

	typedef struct packed {
		logic [1:0] mode;
		logic       count_enable;
		logic       edge_polarity_select;
	} dtc_ctrl_s;

	typedef enum logic [1:0] {
		PW_IDLE = 2'b01,
		PW_MEAS = 2'b10
	} dtc_pw_e;

endpackage

// ==== dtc_timer.sv ====
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dtc_timer (
	input  wire logic        CLOCK_IN,
	input  wire logic        SYS_RST_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	input  wire logic [1:0]  EXT_COUNT_IN,
	output logic      [1:0]  OVF_FLAG_OUT,
	output logic      [1:0]  IRQ_REQ_OUT,
	output logic             WAKE_OUT
);

	logic [dtc_pkg::PRESCALE_W-1:0] presc_r;
	logic                           tick;
	logic                           access;
	logic                           wr_fire;
	logic                           rd_fire;
	logic [5:0]                     idx;
	logic                           aligned;
	logic [1:0]                     irq_en_r;
	logic [1:0]                     flag_r;
	logic [1:0]                     ovf;
	logic [7:0]                     rd_byte;
	logic                           rd_hit;
	logic [7:0]                     hi_byte   [dtc_pkg::NUM_CTR];
	logic [7:0]                     lo_buf    [dtc_pkg::NUM_CTR];
	logic [7:0]                     ctrl_byte [dtc_pkg::NUM_CTR];

	assign idx     = PADDR_IN[7:2];
	assign aligned = (PADDR_IN[1:0] == 2'h0);
	assign access  = PSEL_IN & PENABLE_IN;
	// One wait state: the answer is computed then presented from flops
	assign rd_fire = access & ~PWRITE_IN & ~PREADY_OUT;
	assign wr_fire = access & PWRITE_IN & PREADY_OUT;

	// Shared divide-by-four instruction tick
	always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			presc_r <= '0;
		end else begin
			presc_r <= presc_r + 2'h1;
		end
	end
	assign tick = (presc_r == dtc_pkg::PRESCALE_LAST);

	for (genvar i = 0; i < dtc_pkg::NUM_CTR; i++) begin : g_ctr
		localparam logic [5:0] HI = 6'(dtc_pkg::IDX_C0_HIGH + 6'(i) * dtc_pkg::IDX_CTR_STRIDE);
		localparam logic [5:0] LO = 6'(HI + 6'h01);
		localparam logic [5:0] CT = 6'(HI + 6'h02);

		logic [2:0]                 ext_r;
		logic [dtc_pkg::CTR_W-1:0]  count_r;
		logic [dtc_pkg::CTR_W-1:0]  preload_r;
		logic [7:0]                 buf_r;
		dtc_pkg::dtc_ctrl_s         ctrl_r;
		dtc_pkg::dtc_pw_e           pw_r;
		logic                       act_lvl;
		logic                       lvl;
		logic                       act_edge;
		logic                       blocked;
		logic                       advance;
		logic                       pw_done;
		logic                       wr_hi;
		logic                       wr_lo;
		logic                       wr_ct;
		logic                       rd_hi;

		assign wr_hi = wr_fire & aligned & (idx == HI);
		assign wr_lo = wr_fire & aligned & (idx == LO);
		assign wr_ct = wr_fire & aligned & (idx == CT);
		assign rd_hi = rd_fire & aligned & (idx == HI);

		// Two-stage synchroniser, third stage keeps the previous level
		always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
			if (SYS_RST_IN) begin
				ext_r <= '0;
			end else begin
				ext_r <= {ext_r[1:0], EXT_COUNT_IN[i]};
			end
		end
		assign lvl      = ext_r[1];
		assign act_lvl  = ~ctrl_r.edge_polarity_select;
		assign act_edge = (lvl == act_lvl) & (ext_r[2] != act_lvl);

		// Stall across the access phase of a high-byte read so high and low bytes agree
		assign blocked = access & ~PWRITE_IN & aligned & (idx == HI);

		always_comb begin
			advance = 1'b0;
			pw_done = 1'b0;
			unique case (ctrl_r.mode)
				dtc_pkg::MODE_EVENT: advance = ctrl_r.count_enable & act_edge;
				dtc_pkg::MODE_TIMER: advance = ctrl_r.count_enable & tick;
				dtc_pkg::MODE_PULSE: begin
					advance = ctrl_r.count_enable & (pw_r == dtc_pkg::PW_MEAS)
						& (lvl == act_lvl) & tick;
					pw_done = ctrl_r.count_enable & (pw_r == dtc_pkg::PW_MEAS)
						& (lvl != act_lvl);
				end
				dtc_pkg::MODE_UNUSED: advance = 1'b0;
			endcase
			advance = advance & ~blocked;
		end
		assign ovf[i] = advance & (count_r == '1);

		// Pulse measurement sequencer; a new measurement only after re-enable
		always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
			if (SYS_RST_IN) begin
				pw_r <= dtc_pkg::PW_IDLE;
			end else if (!ctrl_r.count_enable || ctrl_r.mode != dtc_pkg::MODE_PULSE) begin
				pw_r <= dtc_pkg::PW_IDLE;
			end else if (pw_r == dtc_pkg::PW_IDLE && act_edge) begin
				pw_r <= dtc_pkg::PW_MEAS;
			end else if (pw_done) begin
				pw_r <= dtc_pkg::PW_IDLE;
			end
		end

		// A software control write wins over the hardware clear of enable
		always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
			if (SYS_RST_IN) begin
				ctrl_r <= dtc_pkg::dtc_ctrl_s'({dtc_pkg::CTRL_RESET[7:6],
					dtc_pkg::CTRL_RESET[4:3]});
			end else if (wr_ct) begin
				ctrl_r.mode                 <= PWDATA_IN[dtc_pkg::CTRL_MODE_LSB +: 2];
				ctrl_r.count_enable         <= PWDATA_IN[dtc_pkg::CTRL_EN_BIT];
				ctrl_r.edge_polarity_select <= PWDATA_IN[dtc_pkg::CTRL_EDGE_BIT];
			end else if (pw_done) begin
				ctrl_r.count_enable <= 1'b0;
			end
		end

		// Holding buffer shared by low-byte writes and high-byte read latches
		always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
			if (SYS_RST_IN) begin
				buf_r <= '0;
			end else if (wr_lo) begin
				buf_r <= PWDATA_IN[7:0];
			end else if (rd_hi) begin
				buf_r <= count_r[7:0];
			end
		end

		always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
			if (SYS_RST_IN) begin
				preload_r <= '0;
			end else if (wr_hi) begin
				preload_r <= {PWDATA_IN[7:0], buf_r};
			end
		end

		always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
			if (SYS_RST_IN) begin
				count_r <= '0;
			end else if (wr_hi && !ctrl_r.count_enable) begin
				count_r <= {PWDATA_IN[7:0], buf_r};
			end else if (ovf[i]) begin
				count_r <= preload_r;
			end else if (advance) begin
				count_r <= count_r + 16'h0001;
			end
		end

		assign hi_byte[i]   = count_r[15:8];
		assign lo_buf[i]    = buf_r;
		assign ctrl_byte[i] = {ctrl_r.mode, 1'b0, ctrl_r.count_enable,
			ctrl_r.edge_polarity_select, 3'h0};
	end

	// Flags: overflow set wins over a software clear (write 0 clears)
	always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			flag_r   <= '0;
			irq_en_r <= '0;
		end else begin
			if (wr_fire && aligned && idx == dtc_pkg::IDX_IRQ_CTRL) begin
				irq_en_r <= PWDATA_IN[dtc_pkg::IRQ_EN_LSB +: 2];
				flag_r   <= ovf | (flag_r & PWDATA_IN[dtc_pkg::IRQ_FLAG_LSB +: 2]);
			end else begin
				flag_r <= flag_r | ovf;
			end
		end
	end

	always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			OVF_FLAG_OUT <= '0;
			IRQ_REQ_OUT  <= '0;
			WAKE_OUT     <= 1'b0;
		end else begin
			OVF_FLAG_OUT <= flag_r;
			IRQ_REQ_OUT  <= flag_r & irq_en_r;
			WAKE_OUT     <= |ovf;
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		rd_hit  = aligned;
		unique case (idx)
			dtc_pkg::IDX_IRQ_CTRL: begin
				rd_byte = 8'h00;
				rd_byte[dtc_pkg::IRQ_EN_LSB +: 2]   = irq_en_r;
				rd_byte[dtc_pkg::IRQ_FLAG_LSB +: 2] = flag_r;
			end
			dtc_pkg::IDX_C0_HIGH: rd_byte = hi_byte[0];
			dtc_pkg::IDX_C0_LOW:  rd_byte = lo_buf[0];
			dtc_pkg::IDX_C0_CTRL: rd_byte = ctrl_byte[0];
			dtc_pkg::IDX_C1_HIGH: rd_byte = hi_byte[1];
			dtc_pkg::IDX_C1_LOW:  rd_byte = lo_buf[1];
			dtc_pkg::IDX_C1_CTRL: rd_byte = ctrl_byte[1];
			default:              rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			PREADY_OUT  <= 1'b0;
			PRDATA_OUT  <= '0;
			PSLVERR_OUT <= 1'b0;
		end else if (access && !PREADY_OUT) begin
			PREADY_OUT  <= 1'b1;
			PRDATA_OUT  <= PWRITE_IN ? 32'h0000_0000 : {24'h00_0000, rd_hit ? rd_byte : 8'h00};
			PSLVERR_OUT <= ~rd_hit;
		end else begin
			PREADY_OUT  <= 1'b0;
			PSLVERR_OUT <= 1'b0;
		end
	end

endmodule // dtc_timer
`default_nettype wire

// ==== dtc_timer_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_properties (
	input wire logic        CLOCK_IN,
	input wire logic        SYS_RST_IN,
	input wire logic        PSEL_IN,
	input wire logic        PENABLE_IN,
	input wire logic        PWRITE_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic        PREADY_OUT,
	input wire logic        PSLVERR_OUT,
	input wire logic [1:0]  OVF_FLAG_OUT,
	input wire logic [1:0]  IRQ_REQ_OUT,
	input wire logic        WAKE_OUT
);
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (SYS_RST_IN);

	property p_rdy_pulse; PREADY_OUT |=> !PREADY_OUT; endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");

	// One wait state: answer lands in the second access cycle
	property p_rdy_lat; PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT; endproperty
	a_rdy_lat: assert property (p_rdy_lat) else $error("ready late");

	property p_rdata_hi; PREADY_OUT |-> PRDATA_OUT[31:8] == 24'h0; endproperty
	a_rdata_hi: assert property (p_rdata_hi) else $error("read data upper bits set");

	property p_slverr; PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0; endproperty
	a_slverr: assert property (p_slverr) else $error("error response malformed");

	property p_irq_mask; (IRQ_REQ_OUT & ~OVF_FLAG_OUT) == 2'h0; endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("request without flag");

	property p_wake_ovf; |(OVF_FLAG_OUT & ~$past(OVF_FLAG_OUT)) |-> WAKE_OUT || $past(WAKE_OUT);
	endproperty
	a_wake_ovf: assert property (p_wake_ovf) else $error("overflow without wake");

	property p_wake_flag; WAKE_OUT |-> ##[0:1] |OVF_FLAG_OUT; endproperty
	a_wake_flag: assert property (p_wake_flag) else $error("wake without overflow");

	// Flags are sticky; only a completed write two cycles earlier may drop one
	property p_flag_sticky; |($past(OVF_FLAG_OUT) & ~OVF_FLAG_OUT) |->
		$past(PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT, 2); endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
endmodule // dtc_timer_properties

bind dtc_timer dtc_timer_properties u_props (.CLOCK_IN, .SYS_RST_IN, .PSEL_IN, .PENABLE_IN,
	.PWRITE_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .OVF_FLAG_OUT, .IRQ_REQ_OUT, .WAKE_OUT);
`default_nettype wire

// ==== dtc_timer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
	num_checks++; \
	if ((a) !== (e)) begin \
		miscompares++; \
		$display("ERROR %0t got %0h exp %0h", $time, a, e); \
	end \
end
module dtc_timer_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [1:0]  ext = 2'h0;
	logic [31:0] prdata;
	logic        pready, perr, wake;
	logic [1:0]  ovf, irq;
	logic [32:0] expq[$];
	logic [5:0]  b;
	logic [7:0]  hb, lb;
	logic        seen_wake;
	int          miscompares = 0;
	int          num_checks = 0;
	int          n;

	dtc_timer dut (.CLOCK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(perr), .EXT_COUNT_IN(ext),
		.OVF_FLAG_OUT(ovf), .IRQ_REQ_OUT(irq), .WAKE_OUT(wake));

	initial forever #10 clk = ~clk;

	task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
		int t;
		t = 0;
		psel <= 1'b1;
		pwr <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		// Ready is judged at the rising edge that completes the transfer
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		if (pready !== 1'b1) begin
			miscompares++;
			finish_test();
		end
		psel <= 1'b0;
		pen <= 1'b0;
		// Idle cycle so the next setup never reassigns psel in this step
		@(posedge clk);
	endtask

	task automatic rd(input logic [5:0] idx, input logic [8:0] e);
		expq.push_back({e[8], 24'h0, e[7:0]});
		apb(1'b0, idx, 8'h00);
	endtask

	task automatic finish_test();
		if (miscompares == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Read data is taken at the same edge that samples ready high
	always @(posedge clk) if (pready === 1'b1 && psel && pen && !pwr)
		`CHK({perr, prdata}, expq.pop_front())

	initial begin
		#100000;
		miscompares++;
		finish_test();
	end

	initial begin
		void'($urandom(32'h87DA));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(dtc_pkg::IDX_IRQ_CTRL, 9'h000);
		rd(6'h12, 9'h100);
		for (int i = 0; i < 2; i++) begin
			b = 6'(dtc_pkg::IDX_C0_HIGH + dtc_pkg::IDX_CTR_STRIDE * i);
			rd(b + 6'h2, 9'h008);
			apb(1'b1, b + 6'h2, 8'hFF);
			rd(b + 6'h2, 9'h0D8);
			apb(1'b1, b + 6'h2, 8'h88);
			hb = 8'($urandom);
			lb = 8'($urandom);
			apb(1'b1, b + 6'h1, lb);
			apb(1'b1, b, hb);
			// A lone low write must not reach the stopped counter
			apb(1'b1, b + 6'h1, ~lb);
			rd(b, {1'b0, hb});
			rd(b + 6'h1, {1'b0, lb});
			apb(1'b1, b + 6'h1, 8'hFE);
			apb(1'b1, b, 8'hFF);
			apb(1'b1, b + 6'h2, 8'h98);
			n = 0;
			seen_wake = 1'b0;
			while (ovf[i] !== 1'b1 && n < 40) begin
				@(posedge clk);
				if (wake === 1'b1)
					seen_wake = 1'b1;
				n++;
			end
			`CHK(seen_wake, 1'b1)
			`CHK(irq[i], 1'b0)
			rd(b + 6'h2, 9'h098);
			rd(dtc_pkg::IDX_IRQ_CTRL, {1'b0, 8'h20 << i});
			apb(1'b1, dtc_pkg::IDX_IRQ_CTRL, (8'h04 << i) | 8'h60);
			repeat (3) @(posedge clk);
			`CHK(irq[i], 1'b1)
			apb(1'b1, b + 6'h2, 8'h88);
			apb(1'b1, dtc_pkg::IDX_IRQ_CTRL, 8'h00);
			repeat (3) @(posedge clk);
			`CHK(ovf, 2'h0)
			apb(1'b1, b + 6'h1, 8'h00);
			apb(1'b1, b, 8'h00);
			apb(1'b1, b + 6'h2, 8'h50);
			n = $urandom_range(5, 1);
			for (int k = 0; k < n + 1; k++) begin
				ext[i] <= 1'b1;
				repeat (4) @(posedge clk);
				ext[i] <= 1'b0;
				repeat (4) @(posedge clk);
				// Last pulse arrives with the unused mode and must be ignored
				if (k == n - 1)
					apb(1'b1, b + 6'h2, 8'h18);
			end
			rd(b, 9'h000);
			rd(b + 6'h1, {1'b0, 8'(n)});
			ext[i] <= 1'b1;
			apb(1'b1, b + 6'h2, 8'hD0);
			repeat (8) @(posedge clk);
			ext[i] <= 1'b0;
			repeat (8) @(posedge clk);
			rd(b + 6'h2, 9'h0D0);
			ext[i] <= 1'b1;
			repeat (12) @(posedge clk);
			ext[i] <= 1'b0;
			repeat (8) @(posedge clk);
			rd(b + 6'h2, 9'h0C0);
			apb(1'b1, b + 6'h2, 8'h88);
		end
		finish_test();
	end
endmodule // dtc_timer_tb
`default_nettype wire
